// >>> hw/qdsl_ctrl.sv
// serial load and clear controller with apb register window
//
// What this block does
// [RULE1] frame sync low enables the input shifter.
// [RULE2] each falling shift clock edge shifts one data bit into 24 bits.
// [RULE3] after the 24th edge the word is taken and acted upon.
// [RULE4] frame sync rising before the 24th edge discards the partial word.
// [RULE5] host keeps shift clock at most 50 or 25 MHz by supply; the host model clocks it at a 15 ns period, about 66.7 MHz.
// [RULE6] clear low forces all channels to zero or mid scale by select.
// [RULE7] select pin also picks binary or two's complement coding.
// [RULE8] port enable high makes the link ignore sync, clock and data.
// [RULE9] load strobe rising edge moves pending value into all channels together.
// [RULE10] host raises sync at least 15 ns before 24th edge to abort.
// [RULE11] host lowers port enable at least 15 ns before sync falls.
// [RULE12] host waits 130 ns after 24th edge before next sync fall.
// [RULE13] host holds sync high at least 40 or 20 ns between frames.
// [RULE14] load strobe rises 50 ns after 24th edge, stays high 10 ns.
// [RULE15] host keeps port enable low 10 ns past load strobe rise.
// [RULE16] mid scale 2000h binary or 0000h two's; zero scale the reverse.
// [RULE17] the 24-bit word is passed on whole, unparsed.
//
// The APB slave port and the address map were chosen for this implementation.
`default_nettype none
module qdsl_ctrl (
   // clock, reset, enable
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic ce_in,
   // apb slave
   input wire logic [7:0] paddr_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // serial link
   input wire logic shift_clk_in,
   input wire logic frame_sync_n_in,
   input wire logic serial_data_in,
   input wire logic port_enable_n_in,
   // control pins
   input wire logic load_all_strobe_in,
   input wire logic clear_n_in,
   input wire logic clear_level_select_in,
   // channel side
   output qdsl_pkg::qdsl_chan_s chan_out,
   output logic coding_twos_out,
   output logic [23:0] word_out,
   output logic word_valid_out
);
   // link domain
   logic [23:0] rx_word;
   logic rx_toggle;

   qdsl_shift_link u_link (
      .shift_clk_in(shift_clk_in),
      .nrst_in(nrst_in),
      .frame_sync_n_in(frame_sync_n_in),
      .port_enable_n_in(port_enable_n_in),
      .serial_data_in(serial_data_in),
      .rx_word_out(rx_word),
      .rx_toggle_out(rx_toggle)
   );

   // every control pin and the link toggle pass two flops
   qdsl_pkg::qdsl_pins_s pins_raw;
   qdsl_pkg::qdsl_pins_s pins;

   assign pins_raw.load = load_all_strobe_in;
   assign pins_raw.clear_n = clear_n_in;
   assign pins_raw.sel = clear_level_select_in;
   assign pins_raw.done_tgl = rx_toggle;

   qdsl_sync2 #(
      .W($bits(qdsl_pkg::qdsl_pins_s))
   ) u_sync (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .ce_in(ce_in),
      .d_in(pins_raw),
      .q_out(pins)
   );

   // state
   logic prev_load;
   logic prev_tgl;
   logic link_en;
   logic rx_flag;
   logic loaded_flag;
   logic [15:0] word_count;
   logic [23:0] pending;

   // event decode
   wire logic load_rise = pins.load & ~prev_load; // [RULE9]
   wire logic word_evt = pins.done_tgl ^ prev_tgl; // [RULE3]
   // the link word is held still long after the toggle, so a plain capture is safe
   wire logic accept = word_evt & link_en; // [RULE3]
   wire logic clear_act = ~pins.clear_n; // [RULE6]
   wire logic twos = pins.sel; // [RULE7]

   // clear code picked by select and coding
   wire logic [13:0] mid_code = twos ? qdsl_pkg::MID_BTC : qdsl_pkg::MID_USB; // [RULE16]
   wire logic [13:0] zero_code = twos ? qdsl_pkg::ZERO_BTC : qdsl_pkg::ZERO_USB; // [RULE16]
   wire logic [13:0] clear_code = pins.sel ? mid_code : zero_code; // [RULE6]
   wire logic [23:0] clear_word = {10'h000, clear_code};

   // apb decode
   wire logic apb_acc = psel_in & penable_in;
   wire logic apb_done = apb_acc & pready_out;
   wire logic wr_en = apb_done & pwrite_in;
   wire logic aligned = (paddr_in[1:0] == 2'b00);
   wire logic hit_ctrl = aligned & (paddr_in == qdsl_pkg::OFS_CTRL);
   wire logic hit_status = aligned & (paddr_in == qdsl_pkg::OFS_STATUS);
   wire logic hit_pend = aligned & (paddr_in == qdsl_pkg::OFS_PEND);
   wire logic hit_count = aligned & (paddr_in == qdsl_pkg::OFS_COUNT);
   wire logic hit_ch = aligned & (paddr_in >= qdsl_pkg::OFS_CH0) &
      (paddr_in <= qdsl_pkg::OFS_CH3);
   wire logic [7:0] ch_ofs = paddr_in - qdsl_pkg::OFS_CH0;
   wire logic [1:0] ch_idx = ch_ofs[3:2];
   wire logic hit_any = hit_ctrl | hit_status | hit_pend | hit_count | hit_ch;

   // write effects
   wire logic wr_ctrl = wr_en & hit_ctrl;
   wire logic wr_status = wr_en & hit_status;
   wire logic soft_load = wr_ctrl & pwdata_in[qdsl_pkg::CTRL_SOFT_LOAD];
   wire logic do_load = load_rise | soft_load; // [RULE9]
   wire logic clr_rx = wr_status & pwdata_in[qdsl_pkg::ST_RX];
   wire logic clr_loaded = wr_status & pwdata_in[qdsl_pkg::ST_LOADED];

   // sticky flags: a new event beats a clear in the same cycle
   wire logic next_rx = accept | (rx_flag & ~clr_rx);
   wire logic next_loaded = do_load | (loaded_flag & ~clr_loaded);

   // read data
   wire logic [31:0] rd_ctrl = {31'h0000_0000, link_en};
   wire logic [31:0] rd_status = {28'h000_0000, clear_act, twos, loaded_flag, rx_flag};
   wire logic [31:0] rd_pend = {8'h00, pending};
   wire logic [31:0] rd_ch = {8'h00, chan_out.word[ch_idx]};
   wire logic [31:0] rd_count = {16'h0000, word_count};
   wire logic [31:0] rd_data =
      hit_ctrl ? rd_ctrl :
      hit_status ? rd_status :
      hit_pend ? rd_pend :
      hit_ch ? rd_ch :
      hit_count ? rd_count : 32'h0000_0000;

   // apb handshake: one wait state, answer from flops
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         pready_out <= 1'b0;
         prdata_out <= 32'h0000_0000;
         pslverr_out <= 1'b0;
      end else if (ce_in) begin
         pready_out <= apb_acc & ~pready_out;
         prdata_out <= (apb_acc & ~pready_out & ~pwrite_in) ? rd_data : 32'h0000_0000;
         pslverr_out <= apb_acc & ~pready_out & ~hit_any;
      end
   end

   // edge history
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         prev_load <= 1'b0;
         prev_tgl <= 1'b0;
      end else if (ce_in) begin
         prev_load <= pins.load;
         prev_tgl <= pins.done_tgl;
      end
   end

   // control and status registers
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         link_en <= qdsl_pkg::CTRL_LINK_EN_RST;
         rx_flag <= 1'b0;
         loaded_flag <= 1'b0;
         word_count <= qdsl_pkg::COUNT_RST;
      end else if (ce_in) begin
         if (wr_ctrl) begin
            link_en <= pwdata_in[qdsl_pkg::CTRL_LINK_EN];
         end
         rx_flag <= next_rx;
         loaded_flag <= next_loaded;
         if (accept) begin
            word_count <= word_count + 16'h0001;
         end
      end
   end

   // pending word: the last accepted frame, or the clear code while clear is low
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         pending <= qdsl_pkg::WORD_RST;
      end else if (ce_in) begin
         if (clear_act) begin
            pending <= clear_word; // [RULE6]
         end else if (accept) begin
            pending <= rx_word; // [RULE3] [RULE17]
         end
      end
   end

   // channel registers: clear dominates load
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         chan_out <= '0;
      end else if (ce_in) begin
         for (int i = 0; i < qdsl_pkg::CH_N; i++) begin
            if (clear_act) begin
               chan_out.word[i] <= clear_word; // [RULE6]
            end else if (do_load) begin
               chan_out.word[i] <= pending; // [RULE9]
            end
         end
      end
   end

   // word stream and coding
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         word_out <= qdsl_pkg::WORD_RST;
         word_valid_out <= 1'b0;
         coding_twos_out <= 1'b0;
      end else if (ce_in) begin
         if (accept) begin
            word_out <= rx_word; // [RULE17]
         end
         word_valid_out <= accept; // [RULE3]
         coding_twos_out <= twos; // [RULE7]
      end
   end
endmodule // qdsl_ctrl
`default_nettype wire

// >>> inc/qdsl_pkg.sv
// constants and carrier types for the serial load controller
`default_nettype none
package qdsl_pkg;
   // serial frame
   localparam int WORD_W = 24;
   localparam logic [4:0] LAST_BIT = 5'h17;
   localparam logic [4:0] FRAME_DONE = 5'h18;
   localparam int CH_N = 4;
   localparam int CODE_W = 14;
   // clear codes per coding
   localparam logic [13:0] ZERO_USB = 14'h0000;
   localparam logic [13:0] MID_USB = 14'h2000;
   localparam logic [13:0] ZERO_BTC = 14'h2000;
   localparam logic [13:0] MID_BTC = 14'h0000;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_PEND = 8'h08;
   localparam logic [7:0] OFS_CH0 = 8'h0C;
   localparam logic [7:0] OFS_CH3 = 8'h18;
   localparam logic [7:0] OFS_COUNT = 8'h1C;
   // field positions
   localparam int CTRL_LINK_EN = 0;
   localparam int CTRL_SOFT_LOAD = 1;
   localparam int ST_RX = 0;
   localparam int ST_LOADED = 1;
   localparam int ST_TWOS = 2;
   localparam int ST_CLEAR = 3;
   // reset values
   localparam logic CTRL_LINK_EN_RST = 1'b1;
   localparam logic [23:0] WORD_RST = 24'h00_0000;
   localparam logic [15:0] COUNT_RST = 16'h0000;
   // pin bundle that crosses into the register clock
   typedef struct packed {
      logic load;
      logic clear_n;
      logic sel;
      logic done_tgl;
   } qdsl_pins_s;
   // channel words
   typedef struct packed {
      logic [3:0][23:0] word;
   } qdsl_chan_s;
endpackage
`default_nettype wire

// >>> hw/qdsl_sync2.sv
// two flip-flop level synchroniser, W bits wide
`default_nettype none
module qdsl_sync2 #(
   parameter int W = 1
) (
   // clock, reset, enable
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic ce_in,
   // data
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   logic [W-1:0] meta;

   // first stage feeds only the second
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         meta <= '0;
         q_out <= '0;
      end else if (ce_in) begin
         meta <= d_in;
         q_out <= meta;
      end
   end
endmodule // qdsl_sync2
`default_nettype wire

// >>> hw/qdsl_shift_link.sv
// shift-clock domain: 24-bit input shifter with frame abort
`default_nettype none
module qdsl_shift_link (
   // link clock and reset
   input wire logic shift_clk_in,
   input wire logic nrst_in,
   // link pins
   input wire logic frame_sync_n_in,
   input wire logic port_enable_n_in,
   input wire logic serial_data_in,
   // completed word
   output logic [23:0] rx_word_out,
   output logic rx_toggle_out
);
   logic frame_idle;
   logic [4:0] bit_cnt;
   logic [22:0] shreg;
   wire logic [23:0] full_word = {shreg, serial_data_in};

   // shift clock may stop between frames, so idle clears asynchronously
   assign frame_idle = frame_sync_n_in | port_enable_n_in; // [RULE1] [RULE8]

   always_ff @(negedge shift_clk_in or posedge frame_idle or negedge nrst_in) begin
      if (!nrst_in) begin
         bit_cnt <= 5'h00;
         shreg <= 23'h00_0000;
      end else if (frame_idle) begin
         bit_cnt <= 5'h00; // [RULE4]
         shreg <= 23'h00_0000; // [RULE4]
      end else if (bit_cnt != qdsl_pkg::FRAME_DONE) begin
         bit_cnt <= bit_cnt + 5'h01; // [RULE2]
         shreg <= full_word[22:0]; // [RULE2]
      end
   end

   // word leaves only on the 24th edge; partial frames never get here
   always_ff @(negedge shift_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rx_word_out <= qdsl_pkg::WORD_RST;
         rx_toggle_out <= 1'b0;
      end else if (!frame_idle && bit_cnt == qdsl_pkg::LAST_BIT) begin
         rx_word_out <= full_word; // [RULE3] [RULE17]
         rx_toggle_out <= ~rx_toggle_out; // [RULE3]
      end
   end
endmodule // qdsl_shift_link
`default_nettype wire

// >>> test/qdsl_ctrl_checker.sv
// port assertions for the serial load controller
`default_nettype none
module qdsl_ctrl_checker (
   // clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // apb
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic [31:0] prdata_out,
   input wire logic pready_out,
   input wire logic pslverr_out,
   // pins and channel side
   input wire logic load_all_strobe_in,
   input wire logic clear_n_in,
   input wire logic clear_level_select_in,
   input wire qdsl_pkg::qdsl_chan_s chan_out,
   input wire logic coding_twos_out,
   input wire logic [23:0] word_out,
   input wire logic word_valid_out
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   a_one_wait_state: assert property (psel_in && !penable_in |=> !pready_out ##1 pready_out)
      else $error("apb answer not after one wait");
   a_rdata_idle_zero: assert property (!pready_out |-> prdata_out == 32'h0000_0000)
      else $error("read data outside answer");
   a_err_with_ready: assert property (pslverr_out |-> pready_out)
      else $error("error without ready");
   a_word_on_valid: assert property ($changed(word_out) |-> word_valid_out)
      else $error("word changed without valid");
   a_valid_one_pulse: assert property (word_valid_out |=> !word_valid_out)
      else $error("valid longer than one cycle");
   a_chans_equal: assert property (chan_out.word[0] == chan_out.word[3] &&
      chan_out.word[1] == chan_out.word[2] && chan_out.word[0] == chan_out.word[1])
      else $error("channels differ");
   a_load_moves_all: assert property ($rose(load_all_strobe_in) && clear_n_in |->
      ##[2:4] chan_out.word[0] == word_out)
      else $error("load did not reach channels");
   a_clear_forces: assert property (!clear_n_in [*4] |-> chan_out == '0)
      else $error("clear did not force code");
   a_coding_follows: assert property ($stable(clear_level_select_in) [*4] |->
      coding_twos_out == clear_level_select_in)
      else $error("coding does not follow select");
endmodule // qdsl_ctrl_checker
`default_nettype wire

// >>> test/qdsl_host_model.sv
// host serial master model for link and load pins
`default_nettype none
module qdsl_host_model (
   // link pins
   output logic shift_clk_out,
   output logic frame_sync_n_out,
   output logic serial_data_out,
   output logic port_enable_n_out,
   // control pin
   output logic load_all_strobe_out
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      shift_clk_out = 1'b0;
      frame_sync_n_out = 1'b1;
      serial_data_out = 1'b0;
      port_enable_n_out = 1'b1;
      load_all_strobe_out = 1'b0;
   end
   // nbits below 24 ends the frame early, an abort
   task automatic frame(input logic [23:0] w, input int nbits, input logic en_n);
      port_enable_n_out = en_n;
      #20 frame_sync_n_out = 1'b0;
      for (int i = 23; i > 23 - nbits; i--) begin
         serial_data_out = w[i];
         #2.5 shift_clk_out = 1'b1;
         #7.5 shift_clk_out = 1'b0;
         #5;
      end
      frame_sync_n_out = 1'b1;
      // no stale bit left on the released data line
      serial_data_out = ~serial_data_out;
      #150;
   endtask
   // strobe held long enough for the register clock to see it
   task automatic load_pulse();
      // 52 keeps the rising edge off the register clock edge
      #52 load_all_strobe_out = 1'b1;
      #40 load_all_strobe_out = 1'b0;
      #15 port_enable_n_out = 1'b1;
   endtask
endmodule // qdsl_host_model
`default_nettype wire

// >>> test/qdsl_ctrl_tb_top.sv
// testbench top for the serial load controller
`default_nettype none
module qdsl_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_in = 1'b0;
   logic nrst_in = 1'b0;
   logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
   logic [7:0] paddr_in = 8'h00;
   logic [31:0] pwdata_in = 32'h0000_0000;
   logic clear_n_in = 1'b1, clear_level_select_in = 1'b0;
   logic ce_in = 1'b1;
   logic [31:0] prdata_out, rd;
   logic pready_out, pslverr_out, err, sclk, fsync_n, sdata, pen_n, ldstb;
   qdsl_pkg::qdsl_chan_s chan_out;
   logic coding_twos_out, word_valid_out;
   logic [23:0] word_out;
   int num_errors = 0, n_tests = 0;
   always #12.5 clk_in = ~clk_in;
   qdsl_host_model qdsl_host_model_i (.shift_clk_out(sclk), .frame_sync_n_out(fsync_n),
      .serial_data_out(sdata), .port_enable_n_out(pen_n), .load_all_strobe_out(ldstb));
   qdsl_ctrl qdsl_ctrl_i (.clk_in(clk_in), .nrst_in(nrst_in), .ce_in(ce_in),
      .paddr_in(paddr_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
      .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
      .pslverr_out(pslverr_out), .shift_clk_in(sclk), .frame_sync_n_in(fsync_n),
      .serial_data_in(sdata), .port_enable_n_in(pen_n), .load_all_strobe_in(ldstb),
      .clear_n_in(clear_n_in), .clear_level_select_in(clear_level_select_in),
      .chan_out(chan_out), .coding_twos_out(coding_twos_out), .word_out(word_out),
      .word_valid_out(word_valid_out));
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb_rd(input logic [7:0] a);
      int n;
      n = 0;
      @(posedge clk_in);
      psel_in <= 1'b1;
      paddr_in <= a;
      pwrite_in <= 1'b0;
      @(posedge clk_in);
      penable_in <= 1'b1;
      do begin
         @(posedge clk_in);
         n++;
      end while (pready_out !== 1'b1 && n < 20);
      if (n >= 20) num_errors++;
      rd = prdata_out;
      err = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask
   task automatic apb_wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_in);
      psel_in <= 1'b1;
      paddr_in <= a;
      pwrite_in <= 1'b1;
      pwdata_in <= d;
      @(posedge clk_in);
      penable_in <= 1'b1;
      do begin
         @(posedge clk_in);
         n++;
      end while (pready_out !== 1'b1 && n < 20);
      if (n >= 20) num_errors++;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask
   task automatic conclude();
      if (num_errors == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk_in);
      nrst_in <= 1'b1;
      repeat (4) @(posedge clk_in);
      apb_rd(8'h00);
      check("ctrl", rd, 32'h0000_0001);
      apb_rd(8'h20);
      check("unmapped", {31'h0, err}, 32'h0000_0001);
      qdsl_host_model_i.frame(24'hA5_C396, 24, 1'b0);
      check("word", {8'h00, word_out}, 32'h00A5_C396);
      apb_rd(8'h1C);
      check("count", rd, 32'h0000_0001);
      qdsl_host_model_i.frame(24'h12_3456, 10, 1'b0);
      qdsl_host_model_i.frame(24'h0F_F0F0, 24, 1'b0);
      check("word after abort", {8'h00, word_out}, 32'h000F_F0F0);
      qdsl_host_model_i.frame(24'h33_3333, 24, 1'b1);
      apb_rd(8'h1C);
      check("count disabled", rd, 32'h0000_0002);
      apb_rd(8'h04);
      check("rx flag", {31'h0, rd[0]}, 32'h0000_0001);
      apb_wr(8'h04, 32'h0000_0003);
      apb_rd(8'h04);
      check("rx cleared", {30'h0, rd[1:0]}, 32'h0000_0000);
      apb_wr(8'h00, 32'h0000_0000);
      qdsl_host_model_i.frame(24'h55_AA55, 24, 1'b0);
      apb_rd(8'h1C);
      check("count link off", rd, 32'h0000_0002);
      check("word link off", {8'h00, word_out}, 32'h000F_F0F0);
      apb_wr(8'h00, 32'h0000_0001);
      @(posedge clk_in);
      ce_in <= 1'b0;
      qdsl_host_model_i.frame(24'h66_9966, 24, 1'b0);
      check("word frozen", {8'h00, word_out}, 32'h000F_F0F0);
      @(posedge clk_in);
      ce_in <= 1'b1;
      repeat (5) @(posedge clk_in);
      check("word after freeze", {8'h00, word_out}, 32'h0066_9966);
      for (int s = 0; s < 2; s++) begin
         // clear also wipes the pending word, so refill it before each load
         qdsl_host_model_i.frame(24'h0F_F0F0, 24, 1'b0);
         qdsl_host_model_i.load_pulse();
         repeat (4) @(posedge clk_in);
         for (int c = 0; c < 4; c++) begin
            check("chan", {8'h00, chan_out.word[c]}, 32'h000F_F0F0);
         end
         clear_level_select_in <= s[0];
         clear_n_in <= 1'b0;
         repeat (6) @(posedge clk_in);
         check("cleared", {8'h00, chan_out.word[1]}, 32'h0000_0000);
         check("coding", {31'h0, coding_twos_out}, {31'h0, s[0]});
         apb_rd(8'h04);
         check("status", {30'h0, rd[3:2]}, {30'h0, 1'b1, s[0]});
         clear_n_in <= 1'b1;
      end
      qdsl_host_model_i.frame(24'h12_3456, 24, 1'b0);
      apb_wr(8'h00, 32'h0000_0003);
      @(posedge clk_in);
      check("soft load", {8'h00, chan_out.word[2]}, 32'h0012_3456);
      conclude();
   end
   initial begin
      #60us;
      num_errors++;
      conclude();
   end
endmodule // qdsl_ctrl_tb_top
bind qdsl_ctrl qdsl_ctrl_checker qdsl_ctrl_checker_i (.clk_in(clk_in), .nrst_in(nrst_in),
   .psel_in(psel_in), .penable_in(penable_in), .prdata_out(prdata_out),
   .pready_out(pready_out), .pslverr_out(pslverr_out), .load_all_strobe_in(load_all_strobe_in),
   .clear_n_in(clear_n_in), .clear_level_select_in(clear_level_select_in),
   .chan_out(chan_out), .coding_twos_out(coding_twos_out), .word_out(word_out),
   .word_valid_out(word_valid_out));
`default_nettype wire
